// >>> design/orx_defs.svh
// offsets, field positions, opcodes and reset values of the or/rotate execution block
`ifndef ORX_DEFS_SVH
`define ORX_DEFS_SVH

// register byte offsets on the axi4-lite slave
`define ORX_OFS_INSTR    4'h0
`define ORX_OFS_ACC      4'h4
`define ORX_OFS_STATUS   4'h8

// instruction word fields
`define ORX_OPC_HI       15
`define ORX_OPC_LO       8
`define ORX_DEST_BIT     8
`define ORX_OPC_IOR      8'hB3
`define ORX_OPC_ROTL     7'h11
`define ORX_OPC_ROTR     7'h0C

// status register bit positions
`define ORX_ST_CARRY     0
`define ORX_ST_ZERO      1
`define ORX_ST_BUSY      2
`define ORX_ST_UNSUP     3

// reset values
`define ORX_ACC_RST      8'h00
`define ORX_INSTR_RST    16'h0000
`define ORX_CARRY_RST    1'b0
`define ORX_ZERO_RST     1'b0

// axi response codes
`define ORX_RESP_OKAY    2'h0
`define ORX_RESP_SLVERR  2'h2

`endif

// >>> design/orx_pkg.sv
// types shared by the or/rotate execution block
package orx_pkg;

    // execution phases, gray coded along idle-read-exec-write
    typedef enum logic [1:0] {
        ORX_IDLE  = 2'b00,
        ORX_READ  = 2'b01,
        ORX_EXEC  = 2'b11,
        ORX_WRITE = 2'b10
    } orx_phase_e;

    // one instruction word: opcode byte over operand byte
    typedef struct packed {
        logic [7:0] opc;
        logic [7:0] opd;
    } orx_instr_s;

    // status flags kept by the block
    typedef struct packed {
        logic unsup;
        logic zero;
        logic carry;
    } orx_flags_s;

    // axi4-lite slave state
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_held;
        logic        w_held;
        logic [3:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } orx_axi_s;

    // all state of the block apart from the two reset flops
    typedef struct packed {
        orx_phase_e  phase;
        logic        busy;
        orx_instr_s  instr;
        logic [7:0]  acc;
        orx_flags_s  flags;
        logic [7:0]  file_addr;
        logic        file_we;
        logic [7:0]  file_wdata;
        orx_axi_s    axi;
    } orx_state_s;

endpackage

// >>> design/orx_exec.sv
// execution datapath for or-literal, rotate-left and rotate-right-through-carry with axi4-lite access
//
// Functional notes
// - opcode B3 with literal: accumulator becomes accumulator OR literal.
// - the or-literal operand is the instruction's low byte, no file read.
// - opcode 0010001d: rotate addressed register left, bit 7 wraps to bit 0.
// - left rotate neither reads nor changes carry or zero; it clears the unsupported flag.
// - left rotate writes back to the register if d is set, else accumulator.
// - opcode 0001100d: rotate right, old carry into bit 7, bit 0 out.
// - right rotate loads carry with the bit shifted out of bit 0.
// - right rotate with d clear goes to accumulator, d set to register.
`timescale 1ns/1ns
`include "orx_defs.svh"

module orx_exec (
    input  wire logic        MCLK_I,
    input  wire logic        RSTN_I,
    // axi4-lite write address channel
    input  wire logic [3:0]  AWADDR_I,
    input  wire logic        AWVALID_I,
    output logic             AWREADY_O,
    // axi4-lite write data channel
    input  wire logic [31:0] WDATA_I,
    input  wire logic [3:0]  WSTRB_I,
    input  wire logic        WVALID_I,
    output logic             WREADY_O,
    // axi4-lite write response channel
    output logic [1:0]       BRESP_O,
    output logic             BVALID_O,
    input  wire logic        BREADY_I,
    // axi4-lite read address channel
    input  wire logic [3:0]  ARADDR_I,
    input  wire logic        ARVALID_I,
    output logic             ARREADY_O,
    // axi4-lite read data channel
    output logic [31:0]      RDATA_O,
    output logic [1:0]       RRESP_O,
    output logic             RVALID_O,
    input  wire logic        RREADY_I,
    // data register file port
    output logic [7:0]       FILE_ADDR_O,
    input  wire logic [7:0]  FILE_RDATA_I,
    output logic             FILE_WE_O,
    output logic [7:0]       FILE_WDATA_O,
    // core state for the rest of the core
    output logic [7:0]       ACC_O,
    output logic             CARRY_O,
    output logic             ZERO_O,
    output logic             BUSY_O
);

    logic                rst_meta_r;
    logic                rst_n_r;
    orx_pkg::orx_state_s r;
    orx_pkg::orx_state_s n;

    // reset release through two flops; assertion stays asynchronous
    // nothing else reads the raw pin, so a release near the edge cannot split the state
    always_ff @(posedge MCLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // next-state logic: bus slave first, then the execution phases
    always_comb begin
        // scratch for the bus write path
        logic [31:0] wmask;
        logic [15:0] new_word;
        // scratch for the datapath
        logic [7:0]  fv;
        logic [7:0]  res;
        logic        to_file;
        logic        new_carry;
        logic        new_zero;
        logic        known;
        // fields of the word in flight
        logic [7:0]  opc;
        logic        dest;
        logic        is_ior;
        logic        is_rotl;
        logic        is_rotr;

        // defaults: every register holds, the word in flight is decoded once
        n         = r;
        wmask     = 32'h0000_0000;
        new_word  = 16'h0000;
        fv        = FILE_RDATA_I;
        res       = 8'h00;
        to_file   = 1'b0;
        new_carry = r.flags.carry;
        new_zero  = r.flags.zero;
        known     = 1'b1;
        opc       = r.instr[`ORX_OPC_HI:`ORX_OPC_LO];
        dest      = r.instr[`ORX_DEST_BIT];              // shares bit 8 with the opcode byte
        is_ior    = (opc == `ORX_OPC_IOR);
        is_rotl   = (opc[7:1] == `ORX_OPC_ROTL);
        is_rotr   = (opc[7:1] == `ORX_OPC_ROTR);

        // byte lanes of the held write data
        // only the instruction word honours lane 1; acc and status look at lane 0
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{r.axi.wstrb[i]}};
        end

        // address and data are caught independently, in either order
        if (AWVALID_I && r.axi.awready) begin
            n.axi.aw_held = 1'b1;
            n.axi.awaddr  = AWADDR_I;
            n.axi.awready = 1'b0;
        end

        // data may come first; it waits in the held copy for its address
        if (WVALID_I && r.axi.wready) begin
            n.axi.w_held = 1'b1;
            n.axi.wdata  = WDATA_I;
            n.axi.wstrb  = WSTRB_I;
            n.axi.wready = 1'b0;
        end

        // both halves held: perform the write and raise the response
        if (r.axi.aw_held && r.axi.w_held && !r.axi.bvalid) begin
            n.axi.aw_held = 1'b0;
            n.axi.w_held  = 1'b0;
            n.axi.bvalid  = 1'b1;
            n.axi.bresp   = `ORX_RESP_OKAY;
            // decoded from the held address; the live bus may already carry the next one
            unique case (r.axi.awaddr)
                `ORX_OFS_INSTR: begin
                    // a new instruction cannot overtake one in flight
                    if (r.busy) begin
                        n.axi.bresp = `ORX_RESP_SLVERR;
                    end else begin
                        new_word    = (r.instr & ~wmask[15:0]) | (r.axi.wdata[15:0] & wmask[15:0]);
                        n.instr     = new_word;
                        n.file_addr = new_word[7:0];
                        n.phase     = orx_pkg::ORX_READ;
                        n.busy      = 1'b1;
                    end
                end

                // an instruction writing acc in its exec phase on the same edge overrides this write
                `ORX_OFS_ACC: begin
                    if (r.axi.wstrb[0]) begin
                        n.acc = r.axi.wdata[7:0];
                    end
                end

                // busy is read-only: bit 2 of the write data is dropped
                `ORX_OFS_STATUS: begin
                    if (r.axi.wstrb[0]) begin
                        n.flags.carry = r.axi.wdata[`ORX_ST_CARRY];
                        n.flags.zero  = r.axi.wdata[`ORX_ST_ZERO];
                        n.flags.unsup = r.axi.wdata[`ORX_ST_UNSUP];
                    end
                end

                // unmapped offset: answer with an error and change nothing
                default: begin
                    n.axi.bresp = `ORX_RESP_SLVERR;
                end
            endcase
        end

        // response taken: reopen both write channels
        if (r.axi.bvalid && BREADY_I) begin
            n.axi.bvalid  = 1'b0;
            n.axi.awready = 1'b1;
            n.axi.wready  = 1'b1;
        end

        // read: data is registered, so rvalid follows the address by one edge
        if (ARVALID_I && r.axi.arready) begin
            n.axi.arready = 1'b0;
            n.axi.rvalid  = 1'b1;
            n.axi.rresp   = `ORX_RESP_OKAY;
            n.axi.rdata   = 32'h0000_0000;
            unique case (ARADDR_I)
                `ORX_OFS_INSTR: begin
                    n.axi.rdata[15:0] = r.instr;
                end

                `ORX_OFS_ACC: begin
                    n.axi.rdata[7:0] = r.acc;
                end

                // flags and busy gathered into one word; unused bits stay zero
                `ORX_OFS_STATUS: begin
                    n.axi.rdata[`ORX_ST_CARRY] = r.flags.carry;
                    n.axi.rdata[`ORX_ST_ZERO]  = r.flags.zero;
                    n.axi.rdata[`ORX_ST_BUSY]  = r.busy;
                    n.axi.rdata[`ORX_ST_UNSUP] = r.flags.unsup;
                end

                // unmapped offset reads as zero with an error
                default: begin
                    n.axi.rresp = `ORX_RESP_SLVERR;
                end
            endcase
        end
        // read data taken: reopen the address channel
        if (r.axi.rvalid && RREADY_I) begin
            n.axi.rvalid  = 1'b0;
            n.axi.arready = 1'b1;
        end

        // execution phases, one clock each after idle, mirroring decode-read-execute-write
        unique case (r.phase)
            orx_pkg::ORX_IDLE: begin
                // waiting for an instruction write; keep the strobe low
                n.file_we = 1'b0;
            end

            orx_pkg::ORX_READ: begin
                // file address is stable here; the file answers by the next edge
                n.phase = orx_pkg::ORX_EXEC;
            end

            orx_pkg::ORX_EXEC: begin
                // fv is sampled on this edge: a combinational or one-stage registered file both fit
                if (is_ior) begin
                    // literal comes from the word itself; whatever fv carries is ignored
                    res      = r.acc | r.instr.opd;
                    to_file  = 1'b0;
                    new_zero = (res == 8'h00);
                end else if (is_rotl) begin
                    // plain eight-bit rotate: carry neither feeds nor takes a bit
                    res     = {fv[6:0], fv[7]};
                    to_file = dest;
                end else if (is_rotr) begin
                    // nine-bit loop: old carry enters at the top, bit 0 leaves into carry
                    res       = {r.flags.carry, fv[7:1]};
                    new_carry = fv[0];
                    to_file   = dest;
                end else begin
                    // any other opcode is not ours: flag it and touch nothing
                    known = 1'b0;
                end
                // a known opcode commits its flags, then its result to exactly one target
                if (known) begin
                    n.flags.carry = new_carry;
                    n.flags.zero  = new_zero;
                    n.flags.unsup = 1'b0;
                    if (to_file) begin
                        n.file_we    = 1'b1;
                        n.file_wdata = res;
                    end else begin
                        n.acc = res;
                    end
                end else begin
                    // only the unsupported flag moves; acc and the file stay as they were
                    n.flags.unsup = 1'b1;
                end
                n.phase = orx_pkg::ORX_WRITE;
            end

            orx_pkg::ORX_WRITE: begin
                // file write strobe lasts exactly this one cycle
                n.file_we = 1'b0;
                n.busy    = 1'b0;
                n.phase   = orx_pkg::ORX_IDLE;
            end
        endcase
    end

    // the single state register; everything resets to a constant
    always_ff @(posedge MCLK_I or negedge rst_n_r) begin
        if (!rst_n_r) begin
            // clear everything, then set the ready bits and the fields with a named reset value
            r             <= '0;
            r.phase       <= orx_pkg::ORX_IDLE;
            r.instr       <= `ORX_INSTR_RST;
            r.acc         <= `ORX_ACC_RST;
            r.flags.carry <= `ORX_CARRY_RST;
            r.flags.zero  <= `ORX_ZERO_RST;
            r.axi.awready <= 1'b1;
            r.axi.wready  <= 1'b1;
            r.axi.arready <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // all outputs come straight from the state register; bus side first
    assign AWREADY_O    = r.axi.awready;
    assign WREADY_O     = r.axi.wready;
    assign BRESP_O      = r.axi.bresp;
    assign BVALID_O     = r.axi.bvalid;
    assign ARREADY_O    = r.axi.arready;
    assign RDATA_O      = r.axi.rdata;
    assign RRESP_O      = r.axi.rresp;
    assign RVALID_O     = r.axi.rvalid;

    // register file port: address holds until the next instruction, data until the next file write
    assign FILE_ADDR_O  = r.file_addr;
    assign FILE_WE_O    = r.file_we;
    assign FILE_WDATA_O = r.file_wdata;

    // core state seen by the rest of the core
    assign ACC_O        = r.acc;
    assign CARRY_O      = r.flags.carry;
    assign ZERO_O       = r.flags.zero;
    assign BUSY_O       = r.busy;

endmodule

// >>> test/orx_exec_properties.sv
// port checker for the or/rotate execution block
`timescale 1ns/1ns
module orx_exec_props (
    input wire logic       MCLK_I,
    input wire logic       RSTN_I,
    input wire logic [7:0] FILE_RDATA_I,
    input wire logic       FILE_WE_O,
    input wire logic [7:0] FILE_WDATA_O,
    input wire logic [7:0] ACC_O,
    input wire logic       CARRY_O,
    input wire logic       ZERO_O,
    input wire logic       BUSY_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RSTN_I);
    // both rotations of the operand; $past of these gives what the datapath sampled
    logic [7:0] rl;
    logic [7:0] rr;
    assign rl = {FILE_RDATA_I[6:0], FILE_RDATA_I[7]};
    assign rr = {CARRY_O, FILE_RDATA_I[7:1]};
    property p_we_once; FILE_WE_O |=> !FILE_WE_O; endproperty
    a_we_once: assert property (p_we_once) // one write strobe
        else $error("file write strobe too long");
    property p_we_busy; FILE_WE_O |-> BUSY_O; endproperty
    a_we_busy: assert property (p_we_busy) // writes belong to an instruction
        else $error("file write outside an instruction");
    property p_rot; FILE_WE_O |-> FILE_WDATA_O == $past(rl) || FILE_WDATA_O == $past(rr); endproperty
    a_rot: assert property (p_rot) // rotated operand
        else $error("file write data is no rotation");
    property p_rrc_c; FILE_WE_O && FILE_WDATA_O != $past(rl) |-> CARRY_O == $past(FILE_RDATA_I[0]); endproperty
    a_rrc_c: assert property (p_rrc_c) // carry takes bit 0
        else $error("carry not loaded from bit 0");
    property p_rl_flags; FILE_WE_O && FILE_WDATA_O != $past(rr) |-> $stable(CARRY_O) && $stable(ZERO_O); endproperty
    a_rl_flags: assert property (p_rl_flags) // left rotate keeps flags
        else $error("left rotate moved a flag");
    property p_acc_keep; FILE_WE_O |-> $stable(ACC_O); endproperty
    a_acc_keep: assert property (p_acc_keep) // file target spares acc
        else $error("accumulator moved on a file write");
    property p_zero; BUSY_O && $changed(ZERO_O) |-> ZERO_O == (ACC_O == 8'h00); endproperty
    a_zero: assert property (p_zero) // zero follows result
        else $error("zero flag disagrees with accumulator");
    property p_acc_src;
        BUSY_O && $changed(ACC_O) |-> ACC_O == $past(rl) || ACC_O == $past(rr) || (ACC_O | $past(ACC_O)) == ACC_O;
    endproperty
    a_acc_src: assert property (p_acc_src) // or keeps old ones
        else $error("accumulator result of unknown origin");
    c_we: cover property (FILE_WE_O);
    c_zero: cover property ($rose(ZERO_O));
    c_done: cover property ($fell(BUSY_O));
endmodule
bind orx_exec orx_exec_props u_props (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .FILE_RDATA_I(FILE_RDATA_I),
    .FILE_WE_O(FILE_WE_O), .FILE_WDATA_O(FILE_WDATA_O), .ACC_O(ACC_O), .CARRY_O(CARRY_O),
    .ZERO_O(ZERO_O), .BUSY_O(BUSY_O));

// >>> test/orx_file_model.sv
// behavioural data register file facing the execution block
`timescale 1ns/1ns
module orx_file_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] addr_i,
    input  wire logic       we_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o
);
    logic [7:0] mem [256];
    // read is combinational, so data follows the address in the same cycle
    assign rdata_o = mem[addr_i];
    // strobe lands at the edge
    always @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end
endmodule

// >>> test/test_or_literal_and_rotate_exec.sv
// self-checking bench for the or/rotate execution block
`timescale 1ns/1ns
`include "orx_defs.svh"
module test_or_literal_and_rotate_exec;
    logic clk = 1'h0, rst_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
    logic bready = 1'h1, rready = 1'h1, awready, wready, arready, bvalid, rvalid;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [7:0] f_addr, f_rd, f_wd, acc;
    logic f_we, carry, zero, busy;
    int bad_count = 0, n_checks = 0;
    always #2 clk = ~clk;
    // write strobes tied: every register lives in byte 0 or 1
    orx_exec DUT (.MCLK_I(clk), .RSTN_I(rst_n), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
        .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
        .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
        .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .FILE_ADDR_O(f_addr),
        .FILE_RDATA_I(f_rd), .FILE_WE_O(f_we), .FILE_WDATA_O(f_wd), .ACC_O(acc), .CARRY_O(carry),
        .ZERO_O(zero), .BUSY_O(busy));
    orx_file_model fm (.clk_i(clk), .addr_i(f_addr), .we_i(f_we), .wdata_i(f_wd), .rdata_o(f_rd));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // address and data offered together, each dropped at its own handshake
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic ah, wh;
        ah = 1'h0;
        wh = 1'h0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(ah && wh)) begin
            @(negedge clk);
            ah = ah | awready;
            wh = wh | wready;
            @(posedge clk);
            if (ah) awvalid <= 1'h0;
            if (wh) wvalid <= 1'h0;
        end
        do @(negedge clk); while (!bvalid);
        r = bresp;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'h0;
        do @(negedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        @(posedge clk);
    endtask
    // start one instruction and wait for it to retire
    task automatic exec(input logic [15:0] ins);
        wr(`ORX_OFS_INSTR, {16'h0000, ins});
        chk(r, `ORX_RESP_OKAY);
        do @(negedge clk); while (busy);
    endtask
    task automatic t_ior();
        fm.mem[8'h35] = 8'h00;
        wr(`ORX_OFS_ACC, 32'h9A);
        wr(`ORX_OFS_STATUS, 32'h1);
        exec(16'hB335);
        chk(acc, 8'hBF); // literal or-ed in, not the file byte
        chk({carry, zero}, 2'h2); // carry kept, result nonzero
        wr(`ORX_OFS_ACC, 32'h0);
        exec(16'hB300);
        chk({carry, zero}, 2'h3); // zero result sets zero
        rd(`ORX_OFS_STATUS);
        chk(d, 32'h3); // flags seen over the bus
        rd(4'hC);
        chk(r, `ORX_RESP_SLVERR);
    endtask
    task automatic t_rotl();
        fm.mem[8'h10] = 8'hEB;
        wr(`ORX_OFS_ACC, 32'h55);
        wr(`ORX_OFS_STATUS, 32'h3);
        exec(16'h2310);
        chk(fm.mem[8'h10], 8'hD7); // bit 7 wraps to bit 0
        chk(acc, 8'h55); // d set leaves acc
        chk({carry, zero}, 2'h3); // flags kept
        wr(`ORX_OFS_STATUS, 32'h0);
        exec(16'h2210);
        chk(acc, 8'hAF); // d clear goes to acc
        rd(`ORX_OFS_ACC);
        chk(d, 32'hAF); // accumulator seen over the bus
        chk(fm.mem[8'h10], 8'hD7); // source untouched
        chk({carry, zero}, 2'h0); // carry not fed by bit 7
    endtask
    task automatic t_rrc();
        logic [7:0] m;
        logic c;
        m = 8'hE6;
        c = 1'h0;
        fm.mem[8'h20] = m;
        wr(`ORX_OFS_STATUS, 32'h0);
        exec(16'h1820);
        chk(acc, 8'h73); // old carry in at bit 7
        chk(fm.mem[8'h20], m); // d clear keeps source
        repeat (3) begin
            exec(16'h1920);
            {m, c} = {c, m};
            chk(fm.mem[8'h20], m); // nine-bit loop through carry
            chk(carry, c); // carry gets old bit 0
        end
    endtask
    // a foreign opcode must leave acc, file and carry alone and raise the unsupported flag
    task automatic t_unsup();
        fm.mem[8'h44] = 8'h5C;
        wr(`ORX_OFS_ACC, 32'h3C);
        wr(`ORX_OFS_STATUS, 32'h1);
        exec(16'h4444);
        chk(acc, 8'h3C); // no or-literal on another opcode
        chk(fm.mem[8'h44], 8'h5C); // no rotate write-back either
        rd(`ORX_OFS_STATUS);
        chk(d, 32'h9);
        rd(`ORX_OFS_INSTR);
        chk(d, 32'h4444);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        t_ior();
        t_rotl();
        t_rrc();
        t_unsup();
        complete_run();
    end
    // the whole run needs well under a thousand cycles
    initial begin
        #20000;
        bad_count++;
        complete_run();
    end
endmodule
